// File: core/prom_prog_params.svh
// Purpose: Constants for the byte-wide PROM programming controller.
// Assumes: mclk at 100 MHz, 10 ns period.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef PROM_PROG_PARAMS_SVH
`define PROM_PROG_PARAMS_SVH

`define CLK_PERIOD_NS      10
`define ADDR_LOW_LAST      17'h07FFF
`define ADDR_UPPER_FIRST   17'h08000
`define ADDR_UPPER_LAST    17'h1FFFF
`define BLANK_BYTE         8'hFF
`define SETUP_US           2
`define HOLD_US            2
`define PULSE_MIN_US       190
`define PULSE_MAX_US       5250
`define OUT_DELAY_NS       200
`define SETUP_CYC          ((`SETUP_US * 1000) / `CLK_PERIOD_NS)
`define HOLD_CYC           ((`HOLD_US * 1000) / `CLK_PERIOD_NS)
`define PULSE_MIN_CYC      ((`PULSE_MIN_US * 1000) / `CLK_PERIOD_NS)
`define PULSE_MAX_CYC      ((`PULSE_MAX_US * 1000) / `CLK_PERIOD_NS)
`define OUT_DELAY_CYC      \
  ((`OUT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define RETRY_LIMIT        25

`endif

// File: core/prom_prog_pkg.sv
// Purpose: Types for the PROM programming controller.
// Assumes: Nothing beyond the constants header.
// Notes:   Pin groups travel as one packed struct.
package prom_prog_pkg;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_SETUP  = 7'h02,
    ST_PULSE  = 7'h04,
    ST_HOLD   = 7'h08,
    ST_VERIFY = 7'h10,
    ST_NEXT   = 7'h20,
    ST_DONE   = 7'h40
  } prog_state_t;

  typedef struct packed {
    logic        chip_enable_n;
    logic        output_enable_n;
    logic        program_strobe_n;
    logic        vpp_on;
    logic [16:0] prog_address_pins;
  } pin_ctl_t;

  typedef struct packed {
    logic       done;
    logic       fail;
    logic [7:0] tries;
  } prog_status_t;

endpackage

// File: core/prog_image_mem.sv
// Purpose: Source image storage for the programmer, registered read.
// Assumes: Loaded by the user before a run.
// Notes:   Depth covers only the low programmable region.
`timescale 1ns/1ps
module prog_image_mem #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  input  wire logic          mclk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data_r
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge mclk)
  begin
    rd_data_r <= mem[rd_addr];
  end
endmodule

// File: core/prom_programmer.sv
// Purpose: Byte-by-byte write/verify controller driving a PROM port.
// Assumes: Device already in PROM mode; vpp_on steers the supply switch.
// Notes:   Upper region is never written; it is treated as all ones.
`timescale 1ns/1ps
`include "prom_prog_params.svh"

module prom_programmer
  import prom_prog_pkg::*;
#(
  parameter int PULSE_CYC = `PULSE_MIN_CYC + 1000,
  parameter int RETRIES   = `RETRY_LIMIT
) (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          start,
  input  wire logic [16:0]   last_addr,
  input  wire logic          img_wr_en,
  input  wire logic [14:0]   img_wr_addr,
  input  wire logic [7:0]    img_wr_data,
  output pin_ctl_t           pins_r,
  output logic      [7:0]    data_out_r,
  output logic               data_oe_r,
  input  wire logic [7:0]    data_in,
  output prog_status_t       status_r,
  output logic               busy
);
  localparam int CW = 20;
  localparam logic [CW-1:0] SETUP_C = CW'(`SETUP_CYC);
  localparam logic [CW-1:0] HOLD_C  = CW'(`HOLD_CYC);
  localparam logic [CW-1:0] RD_C    = CW'(`SETUP_CYC + `OUT_DELAY_CYC);
  localparam logic [CW-1:0] PULSE_C = CW'(PULSE_CYC);

  prog_state_t   state_r;
  logic [CW-1:0] cnt_r;
  logic [16:0]   addr_r;
  logic [16:0]   end_r;
  logic [7:0]    img_byte;
  logic [7:0]    din_s1_r;
  logic [7:0]    din_s2_r;
  logic          timer_done;

  function automatic logic in_low_region(input logic [16:0] a);
    return a <= `ADDR_LOW_LAST;
  endfunction

  assign timer_done = (cnt_r == '0);
  assign busy = (state_r != ST_IDLE) && (state_r != ST_DONE);

  prog_image_mem #(.AW(15), .DW(8)) u_img (
    .mclk      (mclk),
    .wr_en     (img_wr_en),
    .wr_addr   (img_wr_addr),
    .wr_data   (img_wr_data),
    .rd_addr   (addr_r[14:0]),
    .rd_data_r (img_byte)
  );

  // Data pins are asynchronous to mclk
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end
    else
    begin
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (start)
            state_r <= ST_SETUP;
        ST_SETUP:
          if (timer_done)
            state_r <= ST_PULSE;
        ST_PULSE:
          if (timer_done)
            state_r <= ST_HOLD;
        ST_HOLD:
          if (timer_done)
            state_r <= ST_VERIFY;
        ST_VERIFY:
          if (timer_done)
          begin
            // Synchronized read-back must equal the image byte; else retry or fail
            if (din_s2_r == img_byte)
              state_r <= ST_NEXT;
            else if (status_r.tries >= 8'(RETRIES - 1))
              state_r <= ST_DONE;
            else
              state_r <= ST_SETUP;
          end
        ST_NEXT:
          // Stop at the region edge; the upper image is implied all ones
          if (addr_r == end_r || !in_low_region(addr_r + 17'h1))
            state_r <= ST_DONE;
          else
            state_r <= ST_SETUP;
        ST_DONE:
          if (!start)
            state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_r <= '0;
    else if (state_r == ST_IDLE || state_r == ST_NEXT)
      cnt_r <= SETUP_C;
    else if (!timer_done)
      cnt_r <= cnt_r - CW'(1);
    else
    begin
      unique case (state_r)
        ST_SETUP:  cnt_r <= PULSE_C;
        ST_PULSE:  cnt_r <= HOLD_C;
        ST_HOLD:   cnt_r <= RD_C;
        ST_VERIFY: cnt_r <= SETUP_C;
        default:   cnt_r <= '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_r <= 17'h00000;
      end_r  <= 17'h00000;
    end
    else if (state_r == ST_IDLE && start)
    begin
      addr_r <= 17'h00000;
      end_r  <= in_low_region(last_addr) ? last_addr : `ADDR_LOW_LAST;
    end
    else if (state_r == ST_NEXT && state_r != ST_DONE)
      addr_r <= addr_r + 17'h1;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      status_r <= '0;
    else if (state_r == ST_IDLE && start)
      status_r <= '0;
    else if (state_r == ST_NEXT)
      status_r.tries <= 8'h00;
    else if (state_r == ST_VERIFY && timer_done)
    begin
      if (din_s2_r == img_byte)
        status_r.done <= (addr_r == end_r);
      else if (status_r.tries >= 8'(RETRIES - 1))
        status_r.fail <= 1'b1;
      else
        status_r.tries <= status_r.tries + 8'h01;
    end
  end

  // Pin levels per state; one byte at a time, no page mode
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pins_r     <= '{1'b1, 1'b1, 1'b1, 1'b0, 17'h00000};
      data_out_r <= 8'h00;
      data_oe_r  <= 1'b0;
    end
    else
    begin
      pins_r.prog_address_pins <= addr_r;
      pins_r.vpp_on <= busy;
      data_out_r <= img_byte;
      unique case (state_r)
        ST_SETUP, ST_HOLD:
        begin
          // Inhibit: CE low, OE high, strobe high
          pins_r.chip_enable_n    <= 1'b0;
          pins_r.output_enable_n  <= 1'b1;
          pins_r.program_strobe_n <= 1'b1;
          data_oe_r               <= 1'b1;
        end
        ST_PULSE:
        begin
          pins_r.chip_enable_n    <= 1'b0;
          pins_r.output_enable_n  <= 1'b1;
          pins_r.program_strobe_n <= 1'b0;
          data_oe_r               <= 1'b1;
        end
        ST_VERIFY:
        begin
          pins_r.chip_enable_n    <= 1'b0;
          pins_r.output_enable_n  <= 1'b0;
          pins_r.program_strobe_n <= 1'b1;
          data_oe_r               <= 1'b0;
        end
        default:
        begin
          pins_r.chip_enable_n    <= 1'b1;
          pins_r.output_enable_n  <= 1'b1;
          pins_r.program_strobe_n <= 1'b1;
          data_oe_r               <= 1'b0;
        end
      endcase
    end
  end

  // Never drive data while OE low: no drive fight on data pins
  a_no_contention: assert property (@(posedge mclk) disable iff (!rst_b)
    !(data_oe_r && !pins_r.output_enable_n))
    else $error("data driven while verify read enabled");

  a_addr_low: assert property (@(posedge mclk) disable iff (!rst_b)
    !pins_r.program_strobe_n |-> pins_r.prog_address_pins <= `ADDR_LOW_LAST)
    else $error("write pulse at upper address");

  a_pulse_vpp: assert property (@(posedge mclk) disable iff (!rst_b)
    !pins_r.program_strobe_n |-> pins_r.vpp_on && data_oe_r
      && pins_r.output_enable_n && !pins_r.chip_enable_n)
    else $error("write pulse without write pins");

  sequence s_strobe_fall;
    $fell(pins_r.program_strobe_n);
  endsequence
  a_pulse_min: assert property (@(posedge mclk) disable iff (!rst_b)
    s_strobe_fall |-> !pins_r.program_strobe_n [*8])
    else $error("write pulse too short");

  logic [CW-1:0] plen_r;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      plen_r <= '0;
    else if (!pins_r.program_strobe_n)
      plen_r <= plen_r + CW'(1);
    else
      plen_r <= '0;
  end
  a_pulse_max: assert property (@(posedge mclk) disable iff (!rst_b)
    plen_r <= CW'(`PULSE_MAX_CYC))
    else $error("write pulse too long");
  a_pulse_exact: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(pins_r.program_strobe_n) |-> plen_r == PULSE_C + CW'(1))
    else $error("write pulse width wrong");

  a_verify_after: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(pins_r.program_strobe_n) ##1 (state_r == ST_HOLD)
      |-> ##[1:250] !pins_r.output_enable_n)
    else $error("no verify after pulse");

  a_idle_hiz: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(state_r) == ST_IDLE |-> !data_oe_r && pins_r.chip_enable_n)
    else $error("pins active while idle");

  a_retry_cap: assert property (@(posedge mclk) disable iff (!rst_b)
    status_r.tries < 8'(RETRIES))
    else $error("retry count past limit");
endmodule

// File: testbench/prom_device_model.sv
// Purpose: Behavioural one-time-programmable byte PROM seen at its pins.
// Assumes: Device already in PROM mode; supply levels are ideal.
// Notes:   stuck_mask marks cells that refuse to program, for retries.
`timescale 1ns/1ps
module prom_device_model #(
  parameter int OUT_NS = 200
) (
  input  wire logic        chip_enable_n,
  input  wire logic        output_enable_n,
  input  wire logic        program_strobe_n,
  input  wire logic        vpp_on,
  input  wire logic [16:0] prog_address_pins,
  input  wire logic [7:0]  din,
  input  wire logic [7:0]  stuck_mask,
  output wire logic [7:0]  dout,
  output wire logic        dout_oe,
  output int               upper_writes
);
  logic [7:0] mem [0:32767];
  logic       upper;

  assign upper = prog_address_pins[16:15] != 2'h0;

  initial
  begin
    upper_writes = 0;
    foreach (mem[i]) mem[i] = 8'hFF;
  end

  // Cells only lose ones, so a repeat pulse cannot undo good data
  always @(posedge program_strobe_n)
  begin
    if (!chip_enable_n && output_enable_n && vpp_on)
    begin
      if (upper)
        upper_writes++;
      else
        mem[prog_address_pins[14:0]] &= din | stuck_mask;
    end
  end

  // Worst-case output delay, so the verify wait is really exercised
  assign #(OUT_NS) dout = upper ? 8'hFF : mem[prog_address_pins[14:0]];
  assign dout_oe = !chip_enable_n && !output_enable_n
                   && program_strobe_n;
endmodule

// File: testbench/prom_programmer_bench.sv
// Purpose: Self-checking bench for the PROM programming controller.
// Assumes: Short pulse and retry counts keep the run brief.
// Notes:   Released data pins show the inverse of their last value.
`timescale 1ns/1ps
module prom_programmer_bench;
  import prom_prog_pkg::*;
  localparam int PW = 20;
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  logic         start = 1'b0;
  logic [16:0]  last_addr = 17'h00000;
  logic         img_wr_en = 1'b0;
  logic [14:0]  img_wr_addr = 15'h0000;
  logic [7:0]   img_wr_data = 8'h00;
  pin_ctl_t     pins_r;
  logic [7:0]   data_out_r;
  logic         data_oe_r;
  logic [7:0]   data_in;
  prog_status_t status_r;
  logic         busy;
  logic [7:0]   stuck_mask = 8'h00;
  logic [7:0]   dev_q;
  logic         dev_oe;
  logic [7:0]   last_q = 8'h00;
  int           upper_writes;
  int           n_errors = 0;
  int           checked = 0;
  int           low_cnt = 0;

  always #5 mclk = ~mclk;

  prom_programmer #(.PULSE_CYC(PW), .RETRIES(3)) uut (
    .mclk(mclk), .rst_b(rst_b), .start(start), .last_addr(last_addr),
    .img_wr_en(img_wr_en), .img_wr_addr(img_wr_addr),
    .img_wr_data(img_wr_data), .pins_r(pins_r), .data_out_r(data_out_r),
    .data_oe_r(data_oe_r), .data_in(data_in), .status_r(status_r),
    .busy(busy));

  prom_device_model dev (
    .chip_enable_n(pins_r.chip_enable_n),
    .output_enable_n(pins_r.output_enable_n),
    .program_strobe_n(pins_r.program_strobe_n), .vpp_on(pins_r.vpp_on),
    .prog_address_pins(pins_r.prog_address_pins), .din(data_in),
    .stuck_mask(stuck_mask), .dout(dev_q), .dout_oe(dev_oe),
    .upper_writes(upper_writes));

  assign data_in = data_oe_r ? data_out_r : (dev_oe ? dev_q : ~last_q);
  always @(posedge mclk)
    if (data_oe_r || dev_oe)
      last_q <= data_in;

  task automatic chk_bit(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                          input string m);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s %h/%h", $time, m, got, exp);
    end
  endtask

  // Strobe phase: write mode pins, low region only, fixed width
  always @(posedge mclk)
  begin
    if (rst_b && !pins_r.program_strobe_n)
    begin
      if (low_cnt == 0)
      begin
        chk_bit(pins_r.chip_enable_n, 1'b0, "ce in write");
        chk_bit(pins_r.output_enable_n, 1'b1, "oe in write");
        chk_bit(pins_r.vpp_on, 1'b1, "vpp in write");
        chk_bit(pins_r.prog_address_pins[16], 1'b0, "upper addr");
        chk_bit(pins_r.prog_address_pins[15], 1'b0, "upper addr");
      end
      low_cnt++;
    end
    else if (low_cnt != 0)
    begin
      chk_byte(8'(low_cnt), 8'(PW + 1), "strobe width");
      low_cnt = 0;
    end
  end

  // A run ends in done or fail; a hang is left to the watchdog
  task automatic run_prog(input logic [16:0] last);
    @(posedge mclk) last_addr <= last;
    @(posedge mclk) start <= 1'b1;
    // Two edges so the status of the previous run is cleared first
    repeat (2) @(posedge mclk);
    chk_bit(busy, 1'b1, "busy during run");
    while (status_r.done !== 1'b1 && status_r.fail !== 1'b1)
      @(posedge mclk);
    @(posedge mclk) start <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic scn_reset;
    chk_bit(pins_r.chip_enable_n, 1'b1, "ce at reset");
    chk_bit(pins_r.program_strobe_n, 1'b1, "strobe at reset");
    chk_bit(data_oe_r, 1'b0, "data oe at reset");
    chk_bit(busy, 1'b0, "busy at reset");
  endtask

  task automatic scn_program;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge mclk);
      img_wr_en <= 1'b1;
      img_wr_addr <= 15'(i);
      img_wr_data <= (i == 4) ? 8'h00 : 8'h3C ^ 8'(i * 17);
    end
    @(posedge mclk) img_wr_en <= 1'b0;
    run_prog(17'h00003);
    chk_bit(status_r.fail, 1'b0, "fail on good run");
    chk_bit(status_r.done, 1'b1, "done on good run");
    for (int i = 0; i < 4; i++)
      chk_byte(dev.mem[i], 8'h3C ^ 8'(i * 17), "stored byte");
    chk_byte(dev.mem[4], 8'hFF, "byte past end");
    chk_bit(busy, 1'b0, "busy after run");
  endtask

  task automatic scn_fail;
    @(posedge mclk) stuck_mask <= 8'h01;
    run_prog(17'h00004);
    chk_bit(status_r.fail, 1'b1, "stuck cell not reported");
    chk_bit(status_r.done, 1'b0, "done on failed run");
    chk_byte(status_r.tries, 8'h02, "tries at fail");
    chk_byte(dev.mem[4], 8'h01, "stuck byte");
    chk_byte(8'(upper_writes), 8'h00, "upper region written");
  endtask

  task automatic wrap_up;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    scn_reset;
    @(posedge mclk) rst_b <= 1'b1;
    scn_program;
    scn_fail;
    wrap_up;
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
